/* logic/erb_rom_bus.v */
// Overview of operation
// - strobe latches upper byte; held low during reads as memory output enable
// - shared bus gives upper byte then lower; middle bus carries middle byte
// - data arrives as single bytes on lower eight data lines
// - every claimed read fetches exactly four bytes regardless of byte enables
// - all timing runs on the single bus clock
// - upper byte, strobe high a half clock, upper held one more, then lower
// - wait field sets clocks from lower address to data sample
// - one edge samples data and presents next address
// - all bytes held; ready one clock after last byte
// - three more bytes by incrementing lower address only
// - burst reads disconnected with the first data phase (stop with ready)
// - ignore accesses until memory enable and rom decode enable both set
// - claim reads from window base up to base plus 1M minus 4
// - external address is bus address minus window base
// - read multiple and read line treated as plain read
// - chip select low for wait count plus one per byte
//
// Purpose: expansion ROM read engine between a PCI target and a byte-wide ROM
// Assumes: req_in is a one-cycle pulse from the target front end; single clock
// Notes: half-clock strobe realised as one full cycle of this faster clock
`timescale 1ns/1ps
`include "erb_map.vh"
module erb_rom_bus (
  input wire clk_in,
  input wire reset_n_in,
  input wire req_in,
  input wire [31:0] addr_in,
  input wire [3:0] cmd_in,
  input wire burst_in,
  input wire [11:0] rom_window_base_in,
  input wire memory_space_enable_in,
  input wire rom_decode_enable_in,
  input wire [3:0] upper_ext_addr_field_in,
  input wire [3:0] rom_wait_cycles_in,
  input wire [7:0] ext_byte_data_bus_in,
  output reg claim_out,
  output reg trdy_out,
  output reg stop_out,
  output reg [31:0] read_data_out,
  output reg busy_out,
  output reg [7:0] shared_addr_byte_bus_out,
  output reg [7:0] middle_addr_bus_out,
  output reg addr_strobe_out_enable_n_out,
  output reg rom_chip_select_n_out,
  output reg ext_write_strobe_n_out
);
  localparam ST_IDLE = 6'b00_0001;
  localparam ST_UPPER = 6'b00_0010;
  localparam ST_STROBE = 6'b00_0100;
  localparam ST_HOLD = 6'b00_1000;
  localparam ST_WAIT = 6'b01_0000;
  localparam ST_DONE = 6'b10_0000;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [19:0] offset_r;
  reg [1:0] byte_idx_r;
  reg [3:0] wait_cnt_r;
  reg [3:0] wait_set_r;
  reg burst_r;
  wire hit;
  wire [19:0] offset;
  wire [3:0] load_vec;
  wire [31:0] hold_data;
  wire sample_now;
  wire [7:0] low_byte_nxt;
  // next values of the sequencing and pin registers
  reg [19:0] offset_nxt;
  reg [1:0] byte_idx_nxt;
  reg [3:0] wait_cnt_nxt;
  reg [3:0] wait_set_nxt;
  reg burst_nxt;
  reg claim_nxt;
  reg trdy_nxt;
  reg stop_nxt;
  reg [31:0] read_data_nxt;
  reg busy_nxt;
  reg [7:0] shared_addr_byte_bus_nxt;
  reg [7:0] middle_addr_bus_nxt;
  reg addr_strobe_out_enable_n_nxt;
  reg rom_chip_select_n_nxt;

  erb_window_decode u_decode (
    .addr_in(addr_in),
    .cmd_in(cmd_in),
    .rom_window_base_in(rom_window_base_in),
    .memory_space_enable_in(memory_space_enable_in),
    .rom_decode_enable_in(rom_decode_enable_in),
    .hit_out(hit),
    .offset_out(offset)
  );

  assign sample_now = (state_r == ST_WAIT) && (wait_cnt_r == wait_set_r);
  assign low_byte_nxt = offset_r[7:0] + {6'h00, byte_idx_r} + 8'h01;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hold
      assign load_vec[gi] = sample_now && (byte_idx_r == gi);
      erb_byte_hold u_hold (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(load_vec[gi]),
        .data_in(ext_byte_data_bus_in),
        .data_out(hold_data[gi*8+7:gi*8])
      );
    end
  endgenerate

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (req_in && hit) begin
          state_nxt = ST_UPPER;
        end
      end
      ST_UPPER: begin
        state_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (sample_now && byte_idx_r == `ERB_LAST_BYTE) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // counters and captured request fields
  always @* begin
    offset_nxt = offset_r;
    byte_idx_nxt = byte_idx_r;
    wait_cnt_nxt = wait_cnt_r;
    wait_set_nxt = wait_set_r;
    burst_nxt = burst_r;
    case (state_r)
      ST_IDLE: begin
        if (req_in && hit) begin
          offset_nxt = offset;
          // every fetch starts at byte zero
          byte_idx_nxt = 2'h0;
          wait_set_nxt = rom_wait_cycles_in;
          burst_nxt = burst_in;
        end
      end
      ST_HOLD: begin
        wait_cnt_nxt = 4'h0;
      end
      ST_WAIT: begin
        if (sample_now) begin
          wait_cnt_nxt = 4'h0;
          if (byte_idx_r != `ERB_LAST_BYTE) begin
            // three more bytes, low address only
            byte_idx_nxt = byte_idx_r + 2'h1;
          end
        end else begin
          wait_cnt_nxt = wait_cnt_r + 4'h1;
        end
      end
      default: begin
        wait_cnt_nxt = wait_cnt_r;
      end
    endcase
  end

  // pin and target values for the next edge
  always @* begin
    claim_nxt = 1'b0;
    trdy_nxt = 1'b0;
    stop_nxt = 1'b0;
    read_data_nxt = read_data_out;
    busy_nxt = busy_out;
    shared_addr_byte_bus_nxt = shared_addr_byte_bus_out;
    middle_addr_bus_nxt = middle_addr_bus_out;
    addr_strobe_out_enable_n_nxt = addr_strobe_out_enable_n_out;
    rom_chip_select_n_nxt = rom_chip_select_n_out;
    case (state_r)
      ST_IDLE: begin
        addr_strobe_out_enable_n_nxt = 1'b1;
        rom_chip_select_n_nxt = 1'b1;
        busy_nxt = 1'b0;
        if (req_in && hit) begin
          claim_nxt = 1'b1;
          busy_nxt = 1'b1;
          // strobe low first so the latch sees a rising edge
          addr_strobe_out_enable_n_nxt = 1'b0;
          shared_addr_byte_bus_nxt = {upper_ext_addr_field_in, offset[19:16]};
          middle_addr_bus_nxt = offset[15:8];
        end
      end
      ST_UPPER: begin
        addr_strobe_out_enable_n_nxt = 1'b1;
      end
      ST_STROBE: begin
        addr_strobe_out_enable_n_nxt = 1'b0;
      end
      ST_HOLD: begin
        shared_addr_byte_bus_nxt = offset_r[7:0];
        // select spans wait count plus one per byte, four bytes in all
        rom_chip_select_n_nxt = 1'b0;
      end
      ST_WAIT: begin
        addr_strobe_out_enable_n_nxt = 1'b0;
        if (sample_now) begin
          if (byte_idx_r != `ERB_LAST_BYTE) begin
            shared_addr_byte_bus_nxt = low_byte_nxt;
          end else begin
            rom_chip_select_n_nxt = 1'b1;
          end
        end
      end
      ST_DONE: begin
        addr_strobe_out_enable_n_nxt = 1'b1;
        // ready one clock after last byte
        read_data_nxt = hold_data;
        trdy_nxt = 1'b1;
        stop_nxt = burst_r;
        busy_nxt = 1'b0;
      end
      default: begin
        addr_strobe_out_enable_n_nxt = 1'b1;
        rom_chip_select_n_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      offset_r <= 20'h0_0000;
      byte_idx_r <= 2'h0;
      wait_cnt_r <= 4'h0;
      wait_set_r <= `ERB_WAIT_DEFAULT;
      burst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      offset_r <= offset_nxt;
      byte_idx_r <= byte_idx_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      wait_set_r <= wait_set_nxt;
      burst_r <= burst_nxt;
    end
  end

  // every output straight from a flip-flop
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      claim_out <= 1'b0;
      trdy_out <= 1'b0;
      stop_out <= 1'b0;
      read_data_out <= 32'h0000_0000;
      busy_out <= 1'b0;
      shared_addr_byte_bus_out <= 8'h00;
      middle_addr_bus_out <= 8'h00;
      addr_strobe_out_enable_n_out <= 1'b1;
      rom_chip_select_n_out <= 1'b1;
      ext_write_strobe_n_out <= 1'b1;
    end else begin
      claim_out <= claim_nxt;
      trdy_out <= trdy_nxt;
      stop_out <= stop_nxt;
      read_data_out <= read_data_nxt;
      busy_out <= busy_nxt;
      shared_addr_byte_bus_out <= shared_addr_byte_bus_nxt;
      middle_addr_bus_out <= middle_addr_bus_nxt;
      addr_strobe_out_enable_n_out <= addr_strobe_out_enable_n_nxt;
      rom_chip_select_n_out <= rom_chip_select_n_nxt;
      // reads only; write strobe idles high
      ext_write_strobe_n_out <= 1'b1;
    end
  end
endmodule

/* logic/erb_map.vh */
// Purpose: constants for the expansion ROM boot bus block
// Assumes: 200 MHz clock, PCI target request decoded upstream
// Notes: all timing in clock cycles
`ifndef ERB_MAP_VH
`define ERB_MAP_VH
`define ERB_WAIT_DEFAULT 4'h9
`define ERB_BASE_LSB 20
`define ERB_BASE_MSB 31
`define ERB_OFS_MSB 19
`define ERB_BYTES_PER_READ 3'h4
`define ERB_LAST_BYTE 2'h3
`define ERB_WINDOW_MAX_OFS 20'hF_FFFC
`define ERB_CMD_MEM_READ 4'h6
`define ERB_CMD_MEM_READ_MULT 4'hC
`define ERB_CMD_MEM_READ_LINE 4'hE
`endif

/* logic/erb_window_decode.v */
// Purpose: decide whether a memory read falls in the ROM window
// Assumes: command and address valid in the same cycle as the request
// Notes: combinational; registered by the caller
`timescale 1ns/1ps
`include "erb_map.vh"
module erb_window_decode (
  input wire [31:0] addr_in,
  input wire [3:0] cmd_in,
  input wire [11:0] rom_window_base_in,
  input wire memory_space_enable_in,
  input wire rom_decode_enable_in,
  output wire hit_out,
  output wire [19:0] offset_out
);
  wire [31:0] base_full;
  wire [31:0] diff;
  wire is_read;
  wire in_range;
  assign base_full = {rom_window_base_in, 20'h0_0000};
  assign diff = addr_in - base_full;
  assign offset_out = diff[`ERB_OFS_MSB:0];
  assign is_read = (cmd_in == `ERB_CMD_MEM_READ) || (cmd_in == `ERB_CMD_MEM_READ_MULT) ||
    (cmd_in == `ERB_CMD_MEM_READ_LINE);
  assign in_range = (addr_in[`ERB_BASE_MSB:`ERB_BASE_LSB] == rom_window_base_in) &&
    (diff[`ERB_OFS_MSB:0] <= `ERB_WINDOW_MAX_OFS);
  assign hit_out = memory_space_enable_in && rom_decode_enable_in && is_read && in_range;
endmodule

/* logic/erb_byte_hold.v */
// Purpose: one holding register for a fetched ROM byte
// Assumes: load is a one-cycle pulse
// Notes: instantiated once per byte lane
`timescale 1ns/1ps
module erb_byte_hold (
  input wire clk_in,
  input wire reset_n_in,
  input wire load_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out
);
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      data_out <= 8'h00;
    end else if (load_in) begin
      data_out <= data_in;
    end
  end
endmodule

/* testbench/erb_chk.sv */
// Purpose: port checker for erb_rom_bus
// Assumes: one clock, sync reset
// Notes: counters time the fetch
`timescale 1ns/1ps
module erb_chk (
  input wire clk_in,
  input wire reset_n_in,
  input wire req_in,
  input wire [31:0] addr_in,
  input wire [3:0] cmd_in,
  input wire burst_in,
  input wire [11:0] rom_window_base_in,
  input wire memory_space_enable_in,
  input wire rom_decode_enable_in,
  input wire [3:0] rom_wait_cycles_in,
  input wire claim_out,
  input wire trdy_out,
  input wire stop_out,
  input wire busy_out,
  input wire [7:0] shared_addr_byte_bus_out,
  input wire addr_strobe_out_enable_n_out,
  input wire rom_chip_select_n_out
);
  reg [3:0] w_r;
  reg b_r;
  reg [7:0] cyc_r;
  reg [7:0] low_r;
  wire [7:0] span = {2'b00, w_r, 2'b00} + 8'h04;
  wire hit = memory_space_enable_in && rom_decode_enable_in &&
    addr_in[31:20] == rom_window_base_in && addr_in[19:0] <= 20'hF_FFFC &&
    (cmd_in == 4'h6 || cmd_in == 4'hC || cmd_in == 4'hE);
  always @(posedge clk_in) begin
    if (req_in && !busy_out) begin
      w_r <= rom_wait_cycles_in;
      b_r <= burst_in;
    end
    cyc_r <= claim_out ? 8'h01 : cyc_r + 8'h01;
    low_r <= rom_chip_select_n_out ? 8'h00 : low_r + 8'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_latch;
    !addr_strobe_out_enable_n_out ##1 addr_strobe_out_enable_n_out ##1
      !addr_strobe_out_enable_n_out;
  endsequence
  a_claim_on_hit: assert property (req_in && !busy_out && hit |=> claim_out && busy_out)
    else $error("hit request not claimed");
  a_strobe_latch: assert property (claim_out |-> s_latch)
    else $error("strobe sequence wrong");
  a_upper_held: assert property (claim_out |=> $stable(shared_addr_byte_bus_out) [*2])
    else $error("upper byte not held");
  a_oe_with_cs: assert property (!rom_chip_select_n_out |-> !addr_strobe_out_enable_n_out)
    else $error("output enable off during read");
  a_trdy_time: assert property (busy_out && cyc_r == span + 8'h03 |=> trdy_out)
    else $error("ready late");
  a_cs_span: assert property ($rose(rom_chip_select_n_out) |-> low_r == span - 8'h00)
    else $error("chip select span wrong");
  a_lower_step: assert property (!rom_chip_select_n_out && !$past(rom_chip_select_n_out) &&
    $changed(shared_addr_byte_bus_out) |-> shared_addr_byte_bus_out ==
    $past(shared_addr_byte_bus_out) + 8'h01)
    else $error("lower address step wrong");
  a_stop_burst: assert property (trdy_out || stop_out |-> trdy_out && stop_out == b_r)
    else $error("disconnect wrong");
endmodule

/* testbench/erb_rom_model.sv */
// Purpose: byte-wide ROM with upper address latch
// Assumes: data valid DLY plus one cycles after address change
// Notes: undriven data shows the inverse
`timescale 1ns/1ps
module erb_rom_model #(parameter DLY = 2) (
  input wire clk_in,
  input wire [7:0] addr_byte_in,
  input wire [7:0] mid_in,
  input wire strobe_n_in,
  input wire cs_n_in,
  output wire [7:0] data_out
);
  reg [7:0] up_r;
  reg [7:0] prev_r;
  reg [7:0] cnt_r;
  reg st_prev_r;
  wire [23:0] full_addr = {up_r, mid_in, addr_byte_in};
  wire [7:0] mix = addr_byte_in ^ mid_in ^ up_r ^ 8'h5A;
  // boot signature at the bottom of the rom
  wire [7:0] val = (full_addr == 24'h00_0000) ? 8'h55 :
    ((full_addr == 24'h00_0001) ? 8'hAA : mix);
  always @(posedge clk_in) begin
    // edge-clocked latch takes the upper byte
    if (strobe_n_in && !st_prev_r) up_r <= addr_byte_in;
    st_prev_r <= strobe_n_in;
    prev_r <= addr_byte_in;
    cnt_r <= (addr_byte_in != prev_r) ? 8'h00 : cnt_r + 8'h01;
  end
  assign data_out = (!cs_n_in && !strobe_n_in && cnt_r >= DLY) ? val : ~val;
endmodule

/* testbench/expansion_rom_boot_bus_tb.sv */
// Purpose: self-checking bench for erb_rom_bus
// Assumes: ROM model answers three cycles after address
// Notes: wait counts kept at three or more
`timescale 1ns/1ps
module expansion_rom_boot_bus_tb;
  reg clk_in, reset_n_in, req_in, burst_in;
  reg memory_space_enable_in, rom_decode_enable_in;
  reg [31:0] addr_in;
  reg [3:0] cmd_in, upper_ext_addr_field_in, rom_wait_cycles_in;
  reg [11:0] rom_window_base_in;
  wire [7:0] ext_byte_data_bus_in, shared_addr_byte_bus_out, middle_addr_bus_out;
  wire [31:0] read_data_out;
  wire claim_out, trdy_out, stop_out, busy_out;
  wire addr_strobe_out_enable_n_out, rom_chip_select_n_out, ext_write_strobe_n_out;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  erb_rom_bus u_dut (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .req_in(req_in),
    .addr_in(addr_in),
    .cmd_in(cmd_in),
    .burst_in(burst_in),
    .rom_window_base_in(rom_window_base_in),
    .memory_space_enable_in(memory_space_enable_in),
    .rom_decode_enable_in(rom_decode_enable_in),
    .upper_ext_addr_field_in(upper_ext_addr_field_in),
    .rom_wait_cycles_in(rom_wait_cycles_in),
    .ext_byte_data_bus_in(ext_byte_data_bus_in),
    .claim_out(claim_out),
    .trdy_out(trdy_out),
    .stop_out(stop_out),
    .read_data_out(read_data_out),
    .busy_out(busy_out),
    .shared_addr_byte_bus_out(shared_addr_byte_bus_out),
    .middle_addr_bus_out(middle_addr_bus_out),
    .addr_strobe_out_enable_n_out(addr_strobe_out_enable_n_out),
    .rom_chip_select_n_out(rom_chip_select_n_out),
    .ext_write_strobe_n_out(ext_write_strobe_n_out)
  );
  erb_rom_model #(.DLY(2)) u_rom (.clk_in(clk_in), .addr_byte_in(shared_addr_byte_bus_out),
    .mid_in(middle_addr_bus_out), .strobe_n_in(addr_strobe_out_enable_n_out),
    .cs_n_in(rom_chip_select_n_out), .data_out(ext_byte_data_bus_in));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task t_read(input [31:0] a, input [3:0] c, input [3:0] w, input b);
    integer k, n;
    reg [31:0] exp;
    begin
      for (k = 0; k < 4; k = k + 1)
        exp[8*k +: 8] = (a[7:0] + 8'(k)) ^ a[15:8] ^ {upper_ext_addr_field_in, a[19:16]} ^ 8'h5A;
      req_in <= 1'b1;
      addr_in <= a;
      cmd_in <= c;
      rom_wait_cycles_in <= w;
      burst_in <= b;
      @(posedge clk_in);
      req_in <= 1'b0;
      #1 chk(claim_out, 1);
      n = 0;
      while (trdy_out !== 1'b1 && n < 200) begin
        @(posedge clk_in);
        #1 n = n + 1;
      end
      chk(n, 32'h0000_0008 + 4 * w);
      chk(stop_out, b);
      chk(read_data_out, exp);
      chk(ext_write_strobe_n_out, 1);
      @(posedge clk_in);
    end
  endtask
  task t_refuse(input [31:0] a, input [3:0] c, input m, input r);
    integer n, seen;
    begin
      memory_space_enable_in <= m;
      rom_decode_enable_in <= r;
      req_in <= 1'b1;
      addr_in <= a;
      cmd_in <= c;
      @(posedge clk_in);
      req_in <= 1'b0;
      seen = 0;
      for (n = 0; n < 4; n = n + 1) begin
        @(posedge clk_in);
        #1 if (claim_out !== 1'b0 || busy_out !== 1'b0) seen = 1;
      end
      chk(seen, 0);
      @(posedge clk_in);
      memory_space_enable_in <= 1'b1;
      rom_decode_enable_in <= 1'b1;
      @(posedge clk_in);
    end
  endtask
  task t_sig;
    begin
      // upper field zeroed so the fetch starts at rom address zero
      upper_ext_addr_field_in <= 4'h0;
      @(posedge clk_in);
      req_in <= 1'b1;
      addr_in <= {rom_window_base_in, 20'h0_0000};
      cmd_in <= 4'h6;
      rom_wait_cycles_in <= 4'h9;
      burst_in <= 1'b0;
      @(posedge clk_in);
      req_in <= 1'b0;
      repeat (44) @(posedge clk_in);
      #1 chk(trdy_out, 1);
      chk(read_data_out, 32'h5958_AA55);
      @(posedge clk_in);
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    #5000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    reset_n_in = 0; req_in = 0; burst_in = 0; addr_in = 0; cmd_in = 0;
    // window base programmed with the enables, before any access
    memory_space_enable_in = 1; rom_decode_enable_in = 1; rom_window_base_in = 12'h3A5;
    upper_ext_addr_field_in = 4'h5; rom_wait_cycles_in = 4'h9;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_read(32'h3A50_0000, 4'h6, 4'h9, 1'b0);
    t_read(32'h3A5F_FFFC, 4'hC, 4'h3, 1'b1);
    t_read(32'h3A55_A3FE, 4'hE, 4'hF, 1'b0);
    t_refuse(32'h3A50_0000, 4'h6, 1'b0, 1'b1);
    t_refuse(32'h3A50_0000, 4'h6, 1'b1, 1'b0);
    t_refuse(32'h3A60_0000, 4'h6, 1'b1, 1'b1);
    t_refuse(32'h3A50_0000, 4'h7, 1'b1, 1'b1);
    t_read(32'h3A50_1234, 4'h6, 4'h4, 1'b0);
    t_sig;
    final_report;
  end
endmodule
bind erb_rom_bus erb_chk u_chk (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .req_in(req_in),
  .addr_in(addr_in),
  .cmd_in(cmd_in),
  .burst_in(burst_in),
  .rom_window_base_in(rom_window_base_in),
  .memory_space_enable_in(memory_space_enable_in),
  .rom_decode_enable_in(rom_decode_enable_in),
  .rom_wait_cycles_in(rom_wait_cycles_in),
  .claim_out(claim_out),
  .trdy_out(trdy_out),
  .stop_out(stop_out),
  .busy_out(busy_out),
  .shared_addr_byte_bus_out(shared_addr_byte_bus_out),
  .addr_strobe_out_enable_n_out(addr_strobe_out_enable_n_out),
  .rom_chip_select_n_out(rom_chip_select_n_out)
);
